/* File: src/eeprom_target.sv */
// =====================================================================
// write staging fifo
module stage_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;
   assign in_ready = cnt_r != (AW+1)'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule

// =====================================================================
// serial eeprom target
module eeprom_target #(
   parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // protection and status
   input wire logic wp,
   output logic busy,
   output logic locked
);
   localparam int EW = $bits(eeprom_pkg::wr_entry_t);

   // ==================================================================
   // pin synchronisers
   logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, wp_m, wp_s;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
         {wp_m, wp_s} <= 2'h0;
      end else begin
         {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
         {wp_m, wp_s} <= {wp, wp_m};
      end
   end
   logic scl_rise, scl_fall, start, stop;
   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign start = scl_s & scl_p & sda_p & ~sda_s;
   assign stop = scl_s & scl_p & ~sda_p & sda_s;

   // ==================================================================
   // storage
   logic [7:0] mem [eeprom_pkg::MEM_BYTES];
   logic [7:0] sec [eeprom_pkg::PAGE_BYTES];
   logic [7:0] pbuf [eeprom_pkg::PAGE_BYTES];

   function automatic logic [8:0] adv(eeprom_pkg::area_t a,
                                      logic [8:0] p, logic wr);
      logic [8:0] r;
      r = {p[8:4], p[3:0] + 4'h1};
      if (a == eeprom_pkg::AR_LOCK) begin
         r = p;
      end else if (a == eeprom_pkg::AR_MEM && !wr) begin
         r = p + 9'h001;
      end
      return r;
   endfunction

   // ==================================================================
   // protocol engine
   eeprom_pkg::state_t st_r, st_nxt;
   eeprom_pkg::phase_t ph_r, ph_nxt;
   eeprom_pkg::area_t area_r, area_nxt, warea_r, warea_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, rbyte;
   logic oe_r, oe_nxt, rd_r, rd_nxt, spc_r, spc_nxt;
   logic [8:0] ptr_r, ptr_nxt;
   logic [4:0] wbase_r, wbase_nxt;
   logic seen_r, seen_nxt, cp_r, cp_nxt, lock_r, lock_nxt;
   logic [15:0] mask_r, mask_nxt;
   logic [16:0] bsy_r, bsy_nxt;
   logic push, commit, mem_we, acc;
   logic f_in_ready, f_out_valid, pop;
   eeprom_pkg::wr_entry_t f_in, f_out;

   assign busy = bsy_r != '0;
   assign locked = lock_r;
   assign sda_o = 1'b0;
   assign sda_oe = oe_r;
   assign pop = f_out_valid & ~busy;
   assign commit = cp_r & ~f_out_valid;
   assign mem_we = commit & (warea_r == eeprom_pkg::AR_MEM) & ~wp_s;

   function automatic logic [7:0] sn_byte(logic [3:0] i);
      return eeprom_pkg::SN_VALUE[{i, 3'h0} +: 8];
   endfunction

   always_comb begin
      case (area_r)
         eeprom_pkg::AR_MEM: rbyte = mem[ptr_r];
         eeprom_pkg::AR_SEC: rbyte = sec[ptr_r[3:0]];
         eeprom_pkg::AR_LOCK: rbyte = {6'h00, lock_r, 1'b0};
         default: rbyte = sn_byte(ptr_r[3:0]);
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      ph_nxt = ph_r;
      area_nxt = area_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      oe_nxt = oe_r;
      rd_nxt = rd_r;
      spc_nxt = spc_r;
      ptr_nxt = ptr_r;
      wbase_nxt = wbase_r;
      seen_nxt = seen_r;
      cp_nxt = commit ? 1'b0 : cp_r;
      push = 1'b0;
      acc = 1'b0;
      f_in = '{area: area_r, off: ptr_r[3:0], data: sh_r};
      if (stop) begin
         st_nxt = eeprom_pkg::ST_IDLE;
         oe_nxt = 1'b0;
         cp_nxt = cp_r | seen_r;
         seen_nxt = 1'b0;
      end else if (start && !busy) begin
         st_nxt = eeprom_pkg::ST_RECV;
         ph_nxt = eeprom_pkg::PH_DEV;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
         seen_nxt = 1'b0;
      end else if (!busy) begin
         case (st_r)
            eeprom_pkg::ST_RECV: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[6:0], sda_s};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  st_nxt = eeprom_pkg::ST_ACK;
                  oe_nxt = 1'b1;
                  case (ph_r)
                     eeprom_pkg::PH_DEV: begin
                        rd_nxt = sh_r[eeprom_pkg::DIR_BIT];
                        spc_nxt = sh_r[7:4] == eeprom_pkg::PFX_SPC;
                        if (sh_r[7:4] == eeprom_pkg::PFX_MEM
                            && sh_r[3:2] == 2'h0) begin
                           area_nxt = eeprom_pkg::AR_MEM;
                           ptr_nxt[8] = sh_r[eeprom_pkg::PAGE_BIT];
                        end else if (sh_r[7:4] == eeprom_pkg::PFX_SPC
                                     && sh_r[3:2] == 2'h0) begin
                           if (area_r == eeprom_pkg::AR_MEM) begin
                              area_nxt = eeprom_pkg::AR_SEC;
                           end
                        end else begin
                           st_nxt = eeprom_pkg::ST_IDLE;
                           oe_nxt = 1'b0;
                        end
                     end
                     eeprom_pkg::PH_WADDR: begin
                        if (!spc_r) begin
                           ptr_nxt = {ptr_r[8], sh_r};
                        end else begin
                           ptr_nxt[3:0] = sh_r[3:0];
                           if (sh_r[eeprom_pkg::WA_LOCK_BIT]) begin
                              area_nxt = eeprom_pkg::AR_LOCK;
                           end else if (sh_r[7:6] == eeprom_pkg::WA_SN) begin
                              area_nxt = eeprom_pkg::AR_SN;
                           end else begin
                              area_nxt = eeprom_pkg::AR_SEC;
                           end
                        end
                        wbase_nxt = spc_r ? 5'h00 : {ptr_r[8], sh_r[7:4]};
                     end
                     default: begin
                        acc = !(lock_r && (area_r == eeprom_pkg::AR_SEC
                               || area_r == eeprom_pkg::AR_LOCK));
                        push = acc && area_r != eeprom_pkg::AR_SN
                               && !(area_r == eeprom_pkg::AR_LOCK
                                    && !sh_r[eeprom_pkg::LOCK_BIT]);
                        if (push && !f_in_ready) begin
                           acc = 1'b0;
                        end
                        if (acc) begin
                           ptr_nxt = adv(area_r, ptr_r, 1'b1);
                           seen_nxt = seen_r | push;
                        end else begin
                           st_nxt = eeprom_pkg::ST_IDLE;
                           oe_nxt = 1'b0;
                        end
                     end
                  endcase
               end
            end
            eeprom_pkg::ST_ACK, eeprom_pkg::ST_MACK: begin
               if (st_r == eeprom_pkg::ST_MACK && scl_rise) begin
                  if (sda_s) begin
                     st_nxt = eeprom_pkg::ST_IDLE;
                  end else begin
                     cnt_nxt = 4'h9;
                  end
               end else if (scl_fall && (st_r == eeprom_pkg::ST_ACK
                            || cnt_r == 4'h9)) begin
                  oe_nxt = 1'b0;
                  cnt_nxt = 4'h0;
                  if (rd_r) begin
                     st_nxt = eeprom_pkg::ST_SEND;
                     oe_nxt = ~rbyte[7];
                     sh_nxt = {rbyte[6:0], 1'b0};
                     cnt_nxt = 4'h1;
                  end else begin
                     st_nxt = eeprom_pkg::ST_RECV;
                     ph_nxt = (ph_r == eeprom_pkg::PH_DEV) ?
                        eeprom_pkg::PH_WADDR : eeprom_pkg::PH_WDATA;
                  end
               end
            end
            eeprom_pkg::ST_SEND: begin
               if (scl_fall) begin
                  if (cnt_r == 4'h8) begin
                     oe_nxt = 1'b0;
                     st_nxt = eeprom_pkg::ST_MACK;
                     cnt_nxt = 4'h0;
                     ptr_nxt = adv(area_r, ptr_r, 1'b0);
                  end else begin
                     oe_nxt = ~sh_r[7];
                     sh_nxt = {sh_r[6:0], 1'b0};
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            default: begin
               oe_nxt = 1'b0;
            end
         endcase
      end
   end

   // ==================================================================
   // staging and internal write cycle
   always_comb begin
      mask_nxt = mask_r;
      warea_nxt = warea_r;
      lock_nxt = lock_r;
      bsy_nxt = busy ? bsy_r - 17'h00001 : bsy_r;
      if (start && !busy) begin
         mask_nxt = 16'h0000;
      end
      if (pop) begin
         mask_nxt[f_out.off] = 1'b1;
         warea_nxt = f_out.area;
      end
      if (commit) begin
         mask_nxt = 16'h0000;
         if (mask_r != 16'h0000) begin
            bsy_nxt = 17'(WR_CYCLES - 1);
            if (warea_r == eeprom_pkg::AR_LOCK) begin
               lock_nxt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= eeprom_pkg::ST_IDLE;
         ph_r <= eeprom_pkg::PH_DEV;
         area_r <= eeprom_pkg::AR_MEM;
         warea_r <= eeprom_pkg::AR_MEM;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         oe_r <= 1'b0;
         rd_r <= 1'b0;
         spc_r <= 1'b0;
         ptr_r <= 9'h000;
         wbase_r <= 5'h00;
         seen_r <= 1'b0;
         cp_r <= 1'b0;
         lock_r <= eeprom_pkg::LOCK_RST;
         mask_r <= 16'h0000;
         bsy_r <= 17'h0_0000;
      end else begin
         st_r <= st_nxt;
         ph_r <= ph_nxt;
         area_r <= area_nxt;
         warea_r <= warea_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         oe_r <= oe_nxt;
         rd_r <= rd_nxt;
         spc_r <= spc_nxt;
         ptr_r <= ptr_nxt;
         wbase_r <= wbase_nxt;
         seen_r <= seen_nxt;
         cp_r <= cp_nxt;
         lock_r <= lock_nxt;
         mask_r <= mask_nxt;
         bsy_r <= bsy_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (pop) begin
         pbuf[f_out.off] <= f_out.data;
      end
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
         if (mask_r[i] && mem_we) begin
            mem[{wbase_r, 4'(i)}] <= pbuf[i];
         end
         if (mask_r[i] && commit && !lock_r
             && warea_r == eeprom_pkg::AR_SEC) begin
            sec[i] <= pbuf[i];
         end
      end
   end

   stage_fifo #(.WIDTH(EW), .DEPTH(eeprom_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(push),
      .in_ready(f_in_ready),
      .in_data(f_in),
      .out_valid(f_out_valid),
      .out_ready(~busy),
      .out_data(f_out)
   );

   // ==================================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic dev_byte;
   assign dev_byte = st_r == eeprom_pkg::ST_RECV && ph_r == eeprom_pkg::PH_DEV
      && scl_fall && cnt_r == 4'h8 && !start && !stop && !busy;

   dev_nack_a: assert property (dev_byte && sh_r[7:5] != 3'h5 |=>
      st_r == eeprom_pkg::ST_IDLE && !oe_r)
      else $error("bad device address not released");
   dev_ack_a: assert property (
      dev_byte && sh_r[7:4] == eeprom_pkg::PFX_MEM
      && sh_r[3:2] == 2'h0 |=> oe_r [*2])
      else $error("matching address not acknowledged");
   busy_ignore_a: assert property (busy && !stop |=>
      !oe_r && st_r == $past(st_r))
      else $error("bus answered during write cycle");
   lock_nack_a: assert property (st_r == eeprom_pkg::ST_RECV
      && ph_r == eeprom_pkg::PH_WDATA && scl_fall && cnt_r == 4'h8
      && lock_r && area_r != eeprom_pkg::AR_MEM
      && area_r != eeprom_pkg::AR_SN && !busy && !stop && !start
      |=> !oe_r) else $error("locked sector data acknowledged");
   sn_keep_a: assert property (pop |-> f_out.area != eeprom_pkg::AR_SN)
      else $error("serial number write staged");
   wp_block_a: assert property (wp_s |-> !mem_we)
      else $error("memory written under protect");
   page_wrap_a: assert property (dev_byte == 1'b0 && st_r
      == eeprom_pkg::ST_RECV && ph_r == eeprom_pkg::PH_WDATA
      && st_nxt == eeprom_pkg::ST_ACK |=> ptr_r[8:4] == $past(ptr_r[8:4]))
      else $error("write address left its page");
   busy_len_a: assert property (commit && mask_r != 16'h0000 |=>
      bsy_r == 17'(WR_CYCLES - 1) ##1 busy)
      else $error("write cycle length wrong");
   read_wrap_a: assert property (st_r == eeprom_pkg::ST_SEND
      && st_nxt == eeprom_pkg::ST_MACK && area_r == eeprom_pkg::AR_MEM
      && ptr_r == 9'h1ff |=> ptr_r == 9'h000)
      else $error("read address did not wrap");
   stop_commit_a: assert property (stop && seen_r && !busy |=> cp_r)
      else $error("stop did not start write");

   page_cov_c: cover property (commit && mask_r == 16'hffff);
   lock_cov_c: cover property (!lock_r ##1 lock_r);
   seq_read_c: cover property (st_r == eeprom_pkg::ST_MACK && cnt_r == 4'h9);
endmodule

/* File: common/eeprom_pkg.sv */
// What this block does
// - device address upper nibble 1010 selects data memory; others except 1011 ignored
// - address bits 3:2 are zero, bit 1 picks the upper or lower page
// - address bit 0 high starts a read, low starts a write
// - matching address is acknowledged low; mismatch releases bus until start
// - upper nibble 1011 selects security sector, lock bit and serial number
// - serial number area is never changed by any write
// - write-protect pin high blocks every change to data memory
// - byte write: word address then data, each acknowledged low
// - stop after a write starts the self-timed nonvolatile write
// - during the internal write all bus inputs except stop are ignored
// - page write carries up to sixteen bytes, each one acknowledged
// - write address increments low four bits only, wrapping within page
// - polling address is acknowledged only after the write cycle ends
// - sector write uses word bits 7:6 equal 00, bits 3:0 as offset
// - locked sector: sector write data bytes not acknowledged, sector kept
// - lock command: word bit 6 set, data bit 1 set, sector read-only
// - already locked: data byte of lock command not acknowledged
// - address counter holds last address plus one between transfers
// - reads wrap over the whole memory, writes wrap within the page
// - current address read sends byte at counter; master ends with nack
// - serial number read: word bits 7:6 equal 10, wraps in 16 bytes
// - lock status read returns lock in bit 1, repeated until stop
// - acknowledge drives data low during the ninth clock
package eeprom_pkg;
   localparam logic [3:0] PFX_MEM = 4'ha;
   localparam logic [3:0] PFX_SPC = 4'hb;
   localparam int DIR_BIT = 0;
   localparam int PAGE_BIT = 1;
   localparam int LOCK_BIT = 1;
   localparam int WA_LOCK_BIT = 6;
   localparam logic [1:0] WA_SN = 2'h2;
   localparam logic [1:0] WA_SEC = 2'h0;
   localparam logic LOCK_RST = 1'h0;
   localparam int PAGE_BYTES = 16;
   localparam int MEM_BYTES = 512;
   localparam int FIFO_DEPTH = 4;
   localparam int WR_TIME_US = 5000;
   localparam int CLK_MHZ = 25;
   localparam int WR_CYCLES = WR_TIME_US * CLK_MHZ;
   // serial number contents: arbitrary value
   localparam logic [127:0] SN_VALUE =
      128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
   typedef enum logic [1:0] {
      AR_MEM = 2'h0, AR_SEC = 2'h1, AR_LOCK = 2'h2, AR_SN = 2'h3
   } area_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_RECV = 5'h02, ST_ACK = 5'h04,
      ST_SEND = 5'h08, ST_MACK = 5'h10
   } state_t;
   typedef enum logic [2:0] {
      PH_DEV = 3'h1, PH_WADDR = 3'h2, PH_WDATA = 3'h4
   } phase_t;
   typedef struct packed {
      area_t area;
      logic [3:0] off;
      logic [7:0] data;
   } wr_entry_t;
endpackage

/* File: tb/i2c_master_model.sv */
// =====================================================================
// two-wire bus master model
module i2c_master_model (
   // clock
   input wire logic clk,
   // bus
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // released data line floats to the pull-up level
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one bit cell of 8 clocks: 5 low, 3 high, line sampled late in high
   task automatic bit_io(input logic b, output logic seen);
      sda_drv <= b;
      tick(3);
      scl <= 1'b1;
      tick(2);
      seen = sda_line;
      tick(1);
      scl <= 1'b0;
      tick(2);
   endtask

   // extra low time lets a target release its acknowledge first
   task automatic start_c();
      sda_drv <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask

   task automatic stop_c();
      sda_drv <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // more high asks for another byte, low ends the read
   task automatic recv_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~more, s);
   endtask
endmodule

/* File: tb/eeprom_target_tb_top.sv */
module eeprom_target_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wp = 1'b0;
   logic scl, m_sda, sda_o, sda_oe, busy, locked;
   int n_mismatch = 0;
   int num_checks = 0;
   wire logic sda_w = m_sda & ~(sda_oe & ~sda_o);

   always #20 clk = ~clk;

   eeprom_target #(.WR_CYCLES(200)) dut (.clk(clk), .nrst(nrst),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .wp(wp), .busy(busy), .locked(locked));
   i2c_master_model m (.clk(clk), .scl(scl), .sda_drv(m_sda),
      .sda_line(sda_w));

   // =====================================================================
   // checking and bus tasks
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_byte(input string w, input logic [7:0] e,
      input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask

   task automatic chk_bit(input string w, input logic e, input logic s);
      chk_byte(w, {7'h00, e}, {7'h00, s});
   endtask

   function automatic logic [7:0] sn(input int i);
      return eeprom_pkg::SN_VALUE[8*i +: 8];
   endfunction

   task automatic put(input logic [7:0] b, input logic ea);
      logic a;
      m.send_byte(b, a);
      chk_bit("ack", ea, a);
   endtask

   task automatic get(input logic [7:0] e, input logic more);
      logic [7:0] b;
      m.recv_byte(more, b);
      chk_byte("rdata", e, b);
   endtask

   // dummy write of the word address, then restart for reading
   task automatic seek(input logic [7:0] dev, input logic [7:0] wa);
      m.start_c();
      put(dev, 1'b1);
      put(wa, 1'b1);
      m.start_c();
      put(dev | 8'h01, 1'b1);
   endtask

   task automatic poll(input logic [7:0] dev, output int nref);
      logic a;
      nref = 0;
      a = 1'b0;
      while (a !== 1'b1 && nref < 20) begin
         m.start_c();
         m.send_byte(dev, a);
         if (a !== 1'b1) begin
            nref++;
            if (nref == 1) chk_bit("busy", 1'b1, busy);
         end
      end
      m.stop_c();
      chk_bit("poll_ack", 1'b1, a);
   endtask

   task automatic wr(input logic [7:0] dev, input logic [7:0] wa,
      input logic [7:0] d[$], input logic ea, output int nref);
      m.start_c();
      put(dev, 1'b1);
      put(wa, 1'b1);
      foreach (d[i]) put(d[i], ea);
      m.stop_c();
      poll(dev, nref);
   endtask

   // =====================================================================
   // tests
   initial begin
      logic [7:0] q[$];
      int r;
      int k;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (2500) @(posedge clk);
      chk_bit("locked", 1'b0, locked);
      m.start_c();
      put(8'h90, 1'b0);
      m.start_c();
      put(8'ha4, 1'b0);
      m.stop_c();
      for (int i = 0; i < 18; i++) q.push_back(8'h40 + 8'(i));
      wr(8'ha2, 8'h1e, q, 1'b1, r);
      chk_bit("refused", 1'b1, r > 0);
      seek(8'ha2, 8'h10);
      for (int o = 0; o < 16; o++) begin
         k = (o + 2) % 16;
         if (k < 2) k += 16;
         get(8'h40 + 8'(k), 1'(o < 15));
      end
      m.stop_c();
      wr(8'ha2, 8'hff, '{8'h5a}, 1'b1, r);
      wr(8'ha0, 8'h00, '{8'ha5}, 1'b1, r);
      seek(8'ha2, 8'hff);
      get(8'h5a, 1'b0);
      m.stop_c();
      m.start_c();
      put(8'ha1, 1'b1);
      get(8'ha5, 1'b0);
      m.stop_c();
      wp <= 1'b1;
      wr(8'ha0, 8'h00, '{8'h33}, 1'b1, r);
      wp <= 1'b0;
      seek(8'ha0, 8'h00);
      get(8'ha5, 1'b0);
      m.stop_c();
      m.start_c();
      put(8'ha0, 1'b1);
      put(8'h00, 1'b1);
      put(8'h99, 1'b1);
      seek(8'ha0, 8'h00);
      get(8'ha5, 1'b0);
      m.stop_c();
      seek(8'hb0, 8'h8e);
      get(sn(14), 1'b1);
      get(sn(15), 1'b1);
      get(sn(0), 1'b0);
      m.stop_c();
      wr(8'hb0, 8'h80, '{8'hff}, 1'b1, r);
      seek(8'hb0, 8'h80);
      get(sn(0), 1'b0);
      m.stop_c();
      wr(8'hb0, 8'h0f, '{8'h11, 8'h22}, 1'b1, r);
      seek(8'hb0, 8'h0f);
      get(8'h11, 1'b1);
      get(8'h22, 1'b0);
      m.stop_c();
      seek(8'hb0, 8'h40);
      get(8'h00, 1'b1);
      get(8'h00, 1'b0);
      m.stop_c();
      wr(8'hb0, 8'h40, '{8'hfd}, 1'b1, r);
      chk_bit("locked", 1'b0, locked);
      wr(8'hb0, 8'hc0, '{8'h02}, 1'b1, r);
      chk_bit("locked", 1'b1, locked);
      seek(8'hb0, 8'h40);
      get(8'h02, 1'b1);
      get(8'h02, 1'b0);
      m.stop_c();
      wr(8'hb0, 8'h0f, '{8'h77}, 1'b0, r);
      wr(8'hb0, 8'h40, '{8'h02}, 1'b0, r);
      seek(8'hb0, 8'h0f);
      get(8'h11, 1'b0);
      m.stop_c();
      // six bytes in a row pass through the write staging fifo
      q.delete();
      for (int i = 0; i < 6; i++) q.push_back(8'h10 + 8'(i));
      wr(8'ha0, 8'h30, q, 1'b1, r);
      seek(8'ha0, 8'h30);
      for (int i = 0; i < 6; i++) begin
         get(8'h10 + 8'(i), 1'(i < 5));
      end
      m.stop_c();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule
